// >>> hw/pcl_pkg.sv
// shared constants and types of the parallel configuration loader
package pcl_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int DATA_W      = 32;
  localparam int WORD_AW     = 4;
  localparam int IMAGE_WORDS = 16;
  localparam int SYNC_W      = 36;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int POR_TIME_NS   = 10000;
  localparam int POR_CYCLES    = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] DONE_FALL_EDGES = 2'h2;

  // ---------------------------------------------------------------
  // shift-clock to word ratios
  // ---------------------------------------------------------------
  localparam logic [2:0] RATIO_PLAIN   = 3'h2;
  localparam logic [2:0] RATIO_FEATURE = 3'h4;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COUNT  = 8'h08;
  localparam logic [7:0] REG_CHECK  = 8'h0C;
  localparam logic [7:0] MEM_BASE   = 8'h40;
  localparam logic [7:0] MEM_MASK   = 8'hC0;

  localparam int CTRL_DECOMP_BIT = 0;
  localparam int CTRL_SECURE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  localparam int ST_HEALTH_BIT  = 3;
  localparam int ST_LOADED_BIT  = 4;
  localparam int ST_INIT_BIT    = 5;
  localparam int ST_HEALTH_PIN  = 6;
  localparam int ST_LOADED_PIN  = 7;
  localparam int ST_OPTION_BIT  = 8;

  // option bit inside the first image word
  localparam int OPT_INIT_DONE_BIT = 0;

  // ---------------------------------------------------------------
  // loader states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POR   = 3'b000,
    ST_CLEAR = 3'b001,
    ST_LOAD  = 3'b010,
    ST_DONE  = 3'b011,
    ST_USER  = 3'b100,
    ST_ERROR = 3'b101
  } pcl_state_e;

endpackage : pcl_pkg

// >>> hw/pcl_word_mem.sv
// image word store with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none

module pcl_word_mem
  import pcl_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               we_i,
  input  wire logic [WORD_AW-1:0] waddr_i,
  input  wire logic [DATA_W-1:0]  wdata_i,
  input  wire logic [WORD_AW-1:0] raddr_i,
  output logic      [DATA_W-1:0]  rdata_o
);

  logic [DATA_W-1:0] mem [IMAGE_WORDS];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule : pcl_word_mem

`default_nettype wire

// >>> hw/pcl_loader.sv
// fast parallel configuration loader with AHB-Lite status and image access
//
// How it works
// - in user mode all lines high; request low starts a new configuration
// - health line held low for the whole power-on delay after reset
// - load-complete held low from power-up until configuration ends
// - load-complete released only after the full image passed its check
// - shift edges per word set by decompression and security enables
// - init-done driven low once the enabling option bit is loaded
`timescale 1ns/1ps
`default_nettype none

module pcl_loader
  import pcl_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rstn_i,
  // AHB-Lite slave
  input  wire logic              hsel_i,
  input  wire logic [31:0]       haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic      [31:0]       hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  // configuration link
  input  wire logic              cfg_shift_clock_i,
  input  wire logic [DATA_W-1:0] cfg_data_i,
  input  wire logic              reconfig_request_n_i,
  input  wire logic              cfg_health_n_i,
  output logic                   cfg_health_n_o,
  output logic                   cfg_health_n_oe_n_o,
  input  wire logic              load_complete_i,
  output logic                   load_complete_o,
  output logic                   load_complete_oe_n_o,
  output logic                   init_done_o,
  output logic                   init_done_oe_n_o
);

  // ---------------------------------------------------------------
  // input synchronisers: a bit changes once stages two and three agree
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] s1;
  logic [SYNC_W-1:0] s2;
  logic [SYNC_W-1:0] s3;
  logic [SYNC_W-1:0] filt;

  assign raw = {load_complete_i, cfg_health_n_i, reconfig_request_n_i, cfg_shift_clock_i,
                cfg_data_i};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
          s1[gi]   <= 1'b0;
          s2[gi]   <= 1'b0;
          s3[gi]   <= 1'b0;
          filt[gi] <= 1'b0;
        end else begin
          s1[gi] <= raw[gi];
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          if (s2[gi] == s3[gi]) begin
            filt[gi] <= s3[gi];
          end
        end
      end
    end
  endgenerate

  logic [DATA_W-1:0] data_s;
  logic              sclk_s;
  logic              req_n_s;
  logic              health_s;
  logic              loaded_s;
  logic              sclk_d;
  logic              rise;
  logic              fall;

  assign data_s   = filt[DATA_W-1:0];
  assign sclk_s   = filt[DATA_W];
  assign req_n_s  = filt[DATA_W+1];
  assign health_s = filt[DATA_W+2];
  assign loaded_s = filt[DATA_W+3];
  assign rise     = sclk_s & ~sclk_d;
  assign fall     = ~sclk_s & sclk_d;

  // ---------------------------------------------------------------
  // loader state
  // ---------------------------------------------------------------
  pcl_state_e        state, next_state;
  logic [10:0]       por_cnt, next_por_cnt;
  logic [2:0]        ratio, next_ratio;
  logic [2:0]        phase, next_phase;
  logic [WORD_AW-1:0] count, next_count;
  logic [DATA_W-1:0] hold, next_hold;
  logic [DATA_W-1:0] check, next_check;
  logic              opt_init, next_opt_init;
  logic [1:0]        fall_cnt, next_fall_cnt;
  logic              mem_we, next_mem_we;
  logic [WORD_AW-1:0] mem_waddr, next_mem_waddr;
  logic [DATA_W-1:0] mem_wdata, next_mem_wdata;
  logic [1:0]        ctrl;

  always_comb begin
    next_state     = state;
    next_por_cnt   = por_cnt;
    next_ratio     = ratio;
    next_phase     = phase;
    next_count     = count;
    next_hold      = hold;
    next_check     = check;
    next_opt_init  = opt_init;
    next_fall_cnt  = fall_cnt;
    next_mem_we    = 1'b0;
    next_mem_waddr = mem_waddr;
    next_mem_wdata = mem_wdata;
    case (state)
      ST_POR: begin
        next_por_cnt = por_cnt + 11'h001;
        if (por_cnt == 11'(POR_CYCLES - 1)) begin
          next_state = ST_CLEAR;
        end
      end
      ST_CLEAR: begin
        next_phase    = 3'h0;
        next_count    = '0;
        next_check    = '0;
        next_opt_init = 1'b0;
        next_fall_cnt = 2'h0;
        next_ratio    = (ctrl[CTRL_DECOMP_BIT] | ctrl[CTRL_SECURE_BIT]) ?
                        RATIO_FEATURE : RATIO_PLAIN;
        if (req_n_s) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (rise) begin
          if (phase == 3'h0) begin
            next_hold = data_s;
          end
          if (phase == ratio - 3'h1) begin
            next_phase     = 3'h0;
            next_mem_we    = 1'b1;
            next_mem_waddr = count;
            next_mem_wdata = hold;
            next_check     = check ^ hold;
            next_count     = count + WORD_AW'(1);
            if (count == '0) begin
              next_opt_init = hold[OPT_INIT_DONE_BIT];
            end
            if (count == WORD_AW'(IMAGE_WORDS - 1)) begin
              next_state = ((check ^ hold) == '0) ? ST_DONE : ST_ERROR;
            end
          end else begin
            next_phase = phase + 3'h1;
          end
        end
      end
      ST_DONE: begin
        // only a whole pulse begun after the flag counts, so the trailing fall
        // of the last word never races the flag's own synchroniser
        if (rise) begin
          next_phase = 3'h1;
        end
        if (fall && loaded_s && phase != 3'h0) begin
          next_phase    = 3'h0;
          next_fall_cnt = fall_cnt + 2'h1;
          if (fall_cnt == DONE_FALL_EDGES - 2'h1) begin
            next_state = ST_USER;
          end
        end
      end
      ST_USER: begin
        next_state = ST_USER;
      end
      ST_ERROR: begin
        next_state = ST_ERROR;
      end
      default: begin
        next_state = ST_POR;
      end
    endcase
    if (state != ST_POR && !req_n_s) begin
      next_state    = ST_CLEAR;
      next_opt_init = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state     <= ST_POR;
      por_cnt   <= '0;
      ratio     <= RATIO_PLAIN;
      phase     <= '0;
      count     <= '0;
      hold      <= '0;
      check     <= '0;
      opt_init  <= 1'b0;
      fall_cnt  <= '0;
      mem_we    <= 1'b0;
      mem_waddr <= '0;
      mem_wdata <= '0;
      sclk_d    <= 1'b0;
    end else begin
      state     <= next_state;
      por_cnt   <= next_por_cnt;
      ratio     <= next_ratio;
      phase     <= next_phase;
      count     <= next_count;
      hold      <= next_hold;
      check     <= next_check;
      opt_init  <= next_opt_init;
      fall_cnt  <= next_fall_cnt;
      mem_we    <= next_mem_we;
      mem_waddr <= next_mem_waddr;
      mem_wdata <= next_mem_wdata;
      sclk_d    <= sclk_s;
    end
  end

  // ---------------------------------------------------------------
  // open-drain pins: enable low means the line is pulled low
  // ---------------------------------------------------------------
  logic next_health_oe_n;
  logic next_loaded_oe_n;
  logic next_init_oe_n;

  always_comb begin
    next_health_oe_n = !(next_state == ST_POR || next_state == ST_CLEAR ||
                         next_state == ST_ERROR);
    next_loaded_oe_n = (next_state == ST_DONE || next_state == ST_USER);
    next_init_oe_n   = !(next_opt_init && next_state != ST_USER);
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cfg_health_n_o       <= 1'b0;
      cfg_health_n_oe_n_o  <= 1'b0;
      load_complete_o      <= 1'b0;
      load_complete_oe_n_o <= 1'b0;
      init_done_o          <= 1'b0;
      init_done_oe_n_o     <= 1'b1;
    end else begin
      cfg_health_n_o       <= 1'b0;
      cfg_health_n_oe_n_o  <= next_health_oe_n;
      load_complete_o      <= 1'b0;
      load_complete_oe_n_o <= next_loaded_oe_n;
      init_done_o          <= 1'b0;
      init_done_oe_n_o     <= next_init_oe_n;
    end
  end

  // ---------------------------------------------------------------
  // image store
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] mem_rdata;

  pcl_word_mem u_mem (
    .clk_i   (core_clk_i),
    .we_i    (mem_we),
    .waddr_i (mem_waddr),
    .wdata_i (mem_wdata),
    .raddr_i (haddr_i[WORD_AW+1:2]),
    .rdata_o (mem_rdata)
  );

  // ---------------------------------------------------------------
  // AHB-Lite slave: writes no wait, reads one wait state
  // ---------------------------------------------------------------
  logic        rd_pend, next_rd_pend;
  logic        wr_pend, next_wr_pend;
  logic [7:0]  addr, next_addr;
  logic [1:0]  next_ctrl;
  logic [31:0] next_hrdata;
  logic        next_hreadyout;
  logic [31:0] rd_mux;
  logic        accept;

  assign accept = hsel_i & htrans_i[1] & hready_i;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if ((addr & MEM_MASK) == MEM_BASE) begin
      rd_mux = mem_rdata;
    end else begin
      case (addr)
        REG_CTRL:   rd_mux = {30'h0, ctrl};
        REG_STATUS: rd_mux = {23'h0, opt_init, loaded_s, health_s, init_done_oe_n_o,
                              load_complete_oe_n_o, cfg_health_n_oe_n_o, state};
        REG_COUNT:  rd_mux = {28'h0, count};
        REG_CHECK:  rd_mux = check;
        default:    rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    next_rd_pend   = 1'b0;
    next_wr_pend   = 1'b0;
    next_addr      = addr;
    next_ctrl      = ctrl;
    next_hrdata    = hrdata_o;
    next_hreadyout = 1'b1;
    if (wr_pend && addr == REG_CTRL) begin
      next_ctrl = hwdata_i[1:0];
    end
    if (rd_pend) begin
      next_hrdata = rd_mux;
    end
    if (accept) begin
      next_addr      = haddr_i[7:0];
      next_rd_pend   = ~hwrite_i;
      next_wr_pend   = hwrite_i;
      next_hreadyout = hwrite_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rd_pend     <= 1'b0;
      wr_pend     <= 1'b0;
      addr        <= '0;
      ctrl        <= CTRL_RESET;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      rd_pend     <= next_rd_pend;
      wr_pend     <= next_wr_pend;
      addr        <= next_addr;
      ctrl        <= next_ctrl;
      hrdata_o    <= next_hrdata;
      hreadyout_o <= next_hreadyout;
      hresp_o     <= 1'b0;
    end
  end

endmodule : pcl_loader

`default_nettype wire

// >>> sim/pcl_loader_chk.sv
// concurrent checks on the configuration loader ports
`timescale 1ns/1ps
`default_nettype none

module pcl_loader_chk
  import pcl_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       rstn_i,
  input wire logic       hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic       hwrite_i,
  input wire logic       hready_i,
  input wire logic       hreadyout_o,
  input wire logic       hresp_o,
  input wire logic       cfg_shift_clock_i,
  input wire logic       reconfig_request_n_i,
  input wire logic       cfg_health_n_o,
  input wire logic       cfg_health_n_oe_n_o,
  input wire logic       load_complete_o,
  input wire logic       load_complete_oe_n_o,
  input wire logic       init_done_o,
  input wire logic       init_done_oe_n_o
);
  // ----
  // cycles since release, raw shift-clock edge counts
  // ----
  logic [11:0] por_cnt, next_por_cnt;
  logic [5:0]  rise_cnt, next_rise_cnt;
  logic [1:0]  fall_cnt, next_fall_cnt;
  logic        clk_q, next_clk_q;

  always_comb begin
    next_clk_q    = cfg_shift_clock_i;
    next_por_cnt  = (por_cnt == 12'hFFF) ? por_cnt : por_cnt + 12'h1;
    next_rise_cnt = rise_cnt;
    next_fall_cnt = fall_cnt;
    if (cfg_shift_clock_i && !clk_q && rise_cnt != 6'h3F) next_rise_cnt = rise_cnt + 6'h1;
    if (!cfg_health_n_oe_n_o) next_rise_cnt = 6'h0;
    if (!cfg_shift_clock_i && clk_q && fall_cnt != 2'h3) next_fall_cnt = fall_cnt + 2'h1;
    if (!load_complete_oe_n_o) next_fall_cnt = 2'h0;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      por_cnt  <= 12'h0;
      rise_cnt <= 6'h0;
      fall_cnt <= 2'h0;
      clk_q    <= 1'b0;
    end else begin
      por_cnt  <= next_por_cnt;
      rise_cnt <= next_rise_cnt;
      fall_cnt <= next_fall_cnt;
      clk_q    <= next_clk_q;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  AST_POR_HEALTH_LOW: assert property (
    int'(por_cnt) < POR_CYCLES |-> !cfg_health_n_oe_n_o) else $error("health freed early");
  AST_HEALTH_HOLDS_LC: assert property (
    !cfg_health_n_oe_n_o |-> !load_complete_oe_n_o) else $error("done freed while unhealthy");
  AST_REQ_CLEARS: assert property (
    !reconfig_request_n_i [*6] |-> !cfg_health_n_oe_n_o && !load_complete_oe_n_o)
    else $error("request low ignored");
  AST_LC_AFTER_WORDS: assert property (
    $rose(load_complete_oe_n_o) |-> rise_cnt >= 6'h20) else $error("done before image");
  AST_USER_AFTER_FALLS: assert property (
    $rose(init_done_oe_n_o) |->
      !cfg_health_n_oe_n_o || (load_complete_oe_n_o && fall_cnt >= 2'h2))
    else $error("user mode too early");
  AST_INIT_LOW_IN_LOAD: assert property (
    $fell(init_done_oe_n_o) |-> cfg_health_n_oe_n_o && !load_complete_oe_n_o)
    else $error("init line pulled outside load");
  AST_USER_HOLDS: assert property (
    load_complete_oe_n_o && reconfig_request_n_i |=> load_complete_oe_n_o)
    else $error("done dropped without request");
  AST_PIN_LEVELS: assert property (
    !cfg_health_n_o && !load_complete_o && !init_done_o) else $error("pin drives high");
  AST_READ_WAIT: assert property (
    hsel_i && htrans_i[1] && hready_i && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o && !hresp_o)
    else $error("read wait state wrong");
endmodule : pcl_loader_chk

bind pcl_loader pcl_loader_chk chk (.core_clk_i, .rstn_i, .hsel_i, .htrans_i, .hwrite_i,
  .hready_i, .hreadyout_o, .hresp_o, .cfg_shift_clock_i, .reconfig_request_n_i,
  .cfg_health_n_o, .cfg_health_n_oe_n_o, .load_complete_o, .load_complete_oe_n_o,
  .init_done_o, .init_done_oe_n_o);
`default_nettype wire

// >>> sim/pcl_host.sv
// configuration host model driving shift clock and data words
`timescale 1ns/1ps
`default_nettype none

module pcl_host
  import pcl_pkg::*;
(
  output logic              sclk_o,
  output logic [DATA_W-1:0] data_o
);
  initial begin
    sclk_o = 1'b0;
    data_o = 32'hFFFF0000;
  end

  // clock parks low between frames and after loading
  task automatic pulse();
    sclk_o <= 1'b1;
    #24;
    sclk_o <= 1'b0;
    #24;
  endtask : pulse

  // data turns to garbage after the first pulse: the word must be held inside
  task automatic send_word(input logic [DATA_W-1:0] w, input int r);
    data_o <= w;
    #6;
    pulse();
    data_o <= ~w;
    repeat (r - 1) pulse();
  endtask : send_word

  task automatic falls(input int n);
    repeat (n) pulse();
  endtask : falls
endmodule : pcl_host
`default_nettype wire

// >>> sim/pcl_loader_tb.sv
// self-checking bench for the configuration loader
`timescale 1ns/1ps
`default_nettype none

module pcl_loader_tb;
  import pcl_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rstn_i     = 1'b0;
  logic        hsel       = 1'b0;
  logic        hwrite     = 1'b0;
  logic        req_n      = 1'b1;
  logic [1:0]  htrans     = 2'h0;
  logic [31:0] haddr      = 32'h0;
  logic [31:0] hwdata     = 32'h0;
  logic [31:0] hrdata, rd, sdata;
  logic        hready, hresp, sclk, h_oen, h_o, lc_oen, lc_o, id_oen, id_o, h_w, lc_w;
  logic [31:0] img [16];
  int          mismatches = 0;
  int          n_tests    = 0;

  always #2.5 core_clk_i = ~core_clk_i;
  // pull-ups on the health and load-complete open-drain lines
  assign h_w  = h_oen ? 1'b1 : h_o;
  assign lc_w = lc_oen ? 1'b1 : lc_o;

  pcl_loader uut (.core_clk_i, .rstn_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .cfg_shift_clock_i(sclk), .cfg_data_i(sdata),
    .reconfig_request_n_i(req_n), .cfg_health_n_i(h_w), .cfg_health_n_o(h_o),
    .cfg_health_n_oe_n_o(h_oen), .load_complete_i(lc_w), .load_complete_o(lc_o),
    .load_complete_oe_n_o(lc_oen), .init_done_o(id_o), .init_done_oe_n_o(id_oen));
  pcl_host host (.sclk_o(sclk), .data_o(sdata));

  // ----
  // tasks
  // ----
  task automatic summarize();
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge core_clk_i); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, {24'h0, a}, 32'h0);
    chk(rd & m, e);
  endtask : rchk

  task automatic send(input int r, input logic [31:0] bad, input int lo, input int hi);
    for (int i = lo; i < hi; i++) host.send_word((i == 0) ? img[0] ^ bad : img[i], r);
    repeat (12) @(posedge core_clk_i);
  endtask : send

  task automatic reload(input logic [1:0] c, input logic [31:0] bad);
    req_n <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    rchk(REG_STATUS, 32'h1F, 32'h01);
    ahb(1'b1, {24'h0, REG_CTRL}, {30'h0, c});
    rchk(REG_CTRL, 32'h3, {30'h0, c});
    req_n <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    send(4, bad, 0, 16);
  endtask : reload

  // ----
  // sequence
  // ----
  initial begin
    for (int i = 0; i < 16; i++) img[i] = {8'hC3, 8'(i), 16'h5A3C};
    img[0][0] = 1'b1;
    img[15]   = 32'h0;
    for (int i = 0; i < 15; i++) img[15] = img[15] ^ img[i];
    repeat (6) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rchk(REG_STATUS, 32'h3F, 32'h20);
    repeat (1900) @(posedge core_clk_i);
    rchk(REG_STATUS, 32'h1F, 32'h00);
    repeat (150) @(posedge core_clk_i);
    rchk(REG_STATUS, 32'h1FF, 32'h6A);
    send(2, 32'h0, 0, 8);
    rchk(REG_STATUS, 32'h1FF, 32'h14A);
    send(2, 32'h0, 8, 16);
    rchk(REG_STATUS, 32'h1FF, 32'h1DB);
    rchk(MEM_BASE + 8'h14, 32'hFFFFFFFF, img[5]);
    rchk(8'h20, 32'hFFFFFFFF, 32'h0);
    host.falls(1);
    repeat (10) @(posedge core_clk_i);
    rchk(REG_STATUS, 32'h7, 32'h3);
    host.falls(1);
    repeat (10) @(posedge core_clk_i);
    rchk(REG_STATUS, 32'h1FF, 32'h1FC);
    reload(2'h3, 32'h0);
    rchk(REG_STATUS, 32'h1F, 32'h1B);
    rchk(MEM_BASE + 8'h3C, 32'hFFFFFFFF, img[15]);
    reload(2'h1, 32'h1);
    rchk(REG_STATUS, 32'h1F, 32'h05);
    summarize();
  end

  initial begin
    #150000;
    mismatches++;
    summarize();
  end
endmodule : pcl_loader_tb
`default_nettype wire
